// *** design/irel_pkg.sv ***
// Constants shared by the interrupt request and enable logic
package irel_pkg;
    localparam int NUM_SRC = 16;
    localparam int NUM_FLAG = 31;
    localparam int NUM_EXT = 4;
    localparam int NUM_LVL = 4;
    // Flag vector layout
    localparam int F_EXT0 = 0;
    localparam int F_EXT1 = 1;
    localparam int F_EXT2 = 2;
    localparam int F_EXT3 = 3;
    localparam int F_TMR0 = 4;
    localparam int F_TMR1 = 5;
    localparam int F_S0RX = 6;
    localparam int F_S0TX = 7;
    localparam int F_T2OVF = 8;
    localparam int F_T2EXT = 9;
    localparam int F_SPI = 10;
    localparam int F_CONV = 11;
    localparam int F_ARR_OVF = 12;
    localparam int F_ARR_MOD5 = 18;
    localparam int F_SYS_LO = 19;
    localparam int F_SYS_HI = 25;
    localparam int F_S1RX = 26;
    localparam int F_S1TX = 27;
    localparam int F_KEYPAD = 28;
    localparam int F_TWA = 29;
    localparam int F_TWB = 30;
    // Source numbers, also the fixed polling order
    localparam logic [3:0] S_EXT0 = 4'h0;
    localparam logic [3:0] S_TMR0 = 4'h1;
    localparam logic [3:0] S_EXT1 = 4'h2;
    localparam logic [3:0] S_TMR1 = 4'h3;
    localparam logic [3:0] S_SER0 = 4'h4;
    localparam logic [3:0] S_EXT2 = 4'h6;
    localparam logic [3:0] S_EXT3 = 4'h7;
    localparam logic [3:0] S_SYS = 4'hb;
    // Bit positions in the readback copies of the control registers, and of the global enable in basic_enable_reg
    localparam int TCR_EXT0_BIT = 1;
    localparam int TCR_EXT1_BIT = 3;
    localparam int TCR_TMR0_BIT = 5;
    localparam int TCR_TMR1_BIT = 7;
    localparam int XCR_EXT2_BIT = 1;
    localparam int XCR_EXT3_BIT = 5;
    localparam int GLOBAL_EN_BIT = 7;
    // Reset values and vector table
    localparam logic [30:0] FLAGS_RST = 31'h0;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
endpackage

// *** design/irel_top.sv ***
// Interrupt request flags, enable gating and vectoring arbiter
module irel_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] ext_irq_in_n,
    input wire logic [3:0] ext_trig_type,
    input wire logic [30:0] periph_flag_set,
    input wire logic [30:0] sw_flag_set,
    input wire logic [30:0] sw_flag_clr,
    input wire logic ser_tx_redirect_en,
    input wire logic [7:0] basic_enable_reg,
    input wire logic ext_en_2,
    input wire logic ext_en_3,
    input wire logic [7:0] extended_enable_reg,
    input wire logic [15:0] prio_hi,
    input wire logic [15:0] prio_lo,
    input wire logic instr_final,
    input wire logic ctrl_reg_wr,
    input wire logic reti,
    input wire logic vec_ack,
    output logic [30:0] flags_q,
    output logic [7:0] timer_ctrl_flags_q,
    output logic [7:0] ext_irq_ctrl_flags_q,
    output logic vec_req_q,
    output logic [3:0] vec_src_q,
    output logic [15:0] vec_addr_q,
    output logic [3:0] in_service_q
);

    function automatic logic [1:0] level_of(input logic [15:0] hi,
                                            input logic [15:0] lo,
                                            input logic [3:0] s);
        level_of = {hi[s], lo[s]};
    endfunction

    // True when a handler at this level or above is running
    function automatic logic lvl_blocked(input logic [1:0] lvl,
                                         input logic [3:0] ins);
        logic b;
        b = 1'b0;
        for (int k = 0; k < irel_pkg::NUM_LVL; k++) begin
            if (ins[k] && k >= int'(lvl)) begin
                b = 1'b1;
            end
        end
        lvl_blocked = b;
    endfunction

    logic [3:0] pin_q;
    logic [3:0] pin_d;
    logic [30:0] flags_d;
    logic [30:0] hw_set;
    logic [30:0] auto_clr;
    logic [3:0] ext_edge;
    logic [15:0] req;
    logic [15:0] en;
    logic [15:0] pend;
    logic win_valid;
    logic [3:0] win_src;
    logic [1:0] win_lvl;
    logic take;
    logic vec_req_d;
    logic [3:0] vec_src_d;
    logic [15:0] vec_addr_d;
    logic [3:0] in_service_d;
    logic [7:0] tcr_d;
    logic [7:0] xcr_d;

    assign take = vec_req_q && vec_ack;
    assign pin_d = ext_irq_in_n;

    // Inputs are active low: a fall on the pin is the request edge
    genvar g;
    generate
        for (g = 0; g < irel_pkg::NUM_EXT; g++) begin : g_edge
            assign ext_edge[g] = ext_trig_type[g] && pin_q[g]
                                 && !ext_irq_in_n[g];
        end
    endgenerate

    assign hw_set = {periph_flag_set[30:4], ext_edge};

    // Only the edge external flags and the timer 0/1 flags clear on ack
    always_comb begin
        auto_clr = '0;
        if (take) begin
            unique case (vec_src_q)
                irel_pkg::S_EXT0: auto_clr[irel_pkg::F_EXT0] = 1'b1;
                irel_pkg::S_EXT1: auto_clr[irel_pkg::F_EXT1] = 1'b1;
                irel_pkg::S_EXT2: auto_clr[irel_pkg::F_EXT2] = 1'b1;
                irel_pkg::S_EXT3: auto_clr[irel_pkg::F_EXT3] = 1'b1;
                irel_pkg::S_TMR0: auto_clr[irel_pkg::F_TMR0] = 1'b1;
                irel_pkg::S_TMR1: auto_clr[irel_pkg::F_TMR1] = 1'b1;
                default: auto_clr = '0;
            endcase
        end
    end

    // A set in the same cycle as a clear wins so no event is lost
    always_comb begin
        flags_d = flags_q;
        for (int i = 0; i < irel_pkg::NUM_FLAG; i++) begin
            if (sw_flag_clr[i] || auto_clr[i]) begin
                flags_d[i] = 1'b0;
            end
            if (sw_flag_set[i] || hw_set[i]) begin
                flags_d[i] = 1'b1;
            end
        end
        for (int e = 0; e < irel_pkg::NUM_EXT; e++) begin
            if (!ext_trig_type[e]) begin
                flags_d[e] = !ext_irq_in_n[e];
            end
        end
        tcr_d = '0;
        tcr_d[irel_pkg::TCR_EXT0_BIT] = flags_d[irel_pkg::F_EXT0];
        tcr_d[irel_pkg::TCR_EXT1_BIT] = flags_d[irel_pkg::F_EXT1];
        tcr_d[irel_pkg::TCR_TMR0_BIT] = flags_d[irel_pkg::F_TMR0];
        tcr_d[irel_pkg::TCR_TMR1_BIT] = flags_d[irel_pkg::F_TMR1];
        xcr_d = '0;
        xcr_d[irel_pkg::XCR_EXT2_BIT] = flags_d[irel_pkg::F_EXT2];
        xcr_d[irel_pkg::XCR_EXT3_BIT] = flags_d[irel_pkg::F_EXT3];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_q <= 4'hf;
            flags_q <= irel_pkg::FLAGS_RST;
            timer_ctrl_flags_q <= 8'h00;
            ext_irq_ctrl_flags_q <= 8'h00;
        end else begin
            pin_q <= pin_d;
            flags_q <= flags_d;
            timer_ctrl_flags_q <= tcr_d;
            ext_irq_ctrl_flags_q <= xcr_d;
        end
    end

    // Per-source request terms, one per source
    always_comb begin
        req[0] = flags_q[irel_pkg::F_EXT0];
        req[1] = flags_q[irel_pkg::F_TMR0];
        req[2] = flags_q[irel_pkg::F_EXT1];
        req[3] = flags_q[irel_pkg::F_TMR1];
        req[4] = flags_q[irel_pkg::F_S0RX]
                 | flags_q[irel_pkg::F_S0TX];
        req[5] = flags_q[irel_pkg::F_T2OVF]
                 | flags_q[irel_pkg::F_T2EXT];
        req[6] = flags_q[irel_pkg::F_EXT2];
        req[7] = flags_q[irel_pkg::F_EXT3];
        req[8] = flags_q[irel_pkg::F_SPI];
        req[9] = flags_q[irel_pkg::F_CONV];
        req[10] = |flags_q[irel_pkg::F_ARR_MOD5:
                           irel_pkg::F_ARR_OVF];
        req[11] = |flags_q[irel_pkg::F_SYS_HI:irel_pkg::F_SYS_LO]
                  | (flags_q[irel_pkg::F_S0TX]
                     && ser_tx_redirect_en);
        req[12] = flags_q[irel_pkg::F_S1RX]
                  | flags_q[irel_pkg::F_S1TX];
        req[13] = flags_q[irel_pkg::F_KEYPAD];
        req[14] = flags_q[irel_pkg::F_TWA];
        req[15] = flags_q[irel_pkg::F_TWB];
    end

    assign en = {extended_enable_reg, ext_en_3, ext_en_2,
                 basic_enable_reg[5:0]};
    assign pend = req & en
                  & {16{basic_enable_reg[irel_pkg::GLOBAL_EN_BIT]}};

    // Scan down so that among equal levels the lowest number wins
    always_comb begin
        win_valid = 1'b0;
        win_src = 4'h0;
        win_lvl = 2'h0;
        for (int i = irel_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i] && (!win_valid
                || level_of(prio_hi, prio_lo, 4'(i)) >= win_lvl)) begin
                win_valid = 1'b1;
                win_src = 4'(i);
                win_lvl = level_of(prio_hi, prio_lo, 4'(i));
            end
        end
    end

    // Flags sampled into flags_q are polled here; the strobe is re-judged
    // every cycle so a cancelled request withdraws before it is acked
    always_comb begin
        vec_req_d = 1'b0;
        vec_src_d = vec_src_q;
        vec_addr_d = vec_addr_q;
        in_service_d = in_service_q;
        if (take) begin
            in_service_d[level_of(prio_hi, prio_lo, vec_src_q)] = 1'b1;
        end else if (reti) begin
            for (int k = 0; k < irel_pkg::NUM_LVL; k++) begin
                if (in_service_q[k] && !(|(in_service_q >> (k + 1)))) begin
                    in_service_d[k] = 1'b0;
                end
            end
        end
        if (win_valid && !lvl_blocked(win_lvl, in_service_q)
            && instr_final && !ctrl_reg_wr && !reti && !take) begin
            vec_req_d = 1'b1;
            vec_src_d = win_src;
            vec_addr_d = 16'(irel_pkg::VEC_BASE
                             + irel_pkg::VEC_STEP * win_src);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vec_req_q <= 1'b0;
            vec_src_q <= 4'h0;
            vec_addr_q <= irel_pkg::VEC_BASE;
            in_service_q <= 4'h0;
        end else begin
            vec_req_q <= vec_req_d;
            vec_src_q <= vec_src_d;
            vec_addr_q <= vec_addr_d;
            in_service_q <= in_service_d;
        end
    end

    // Helper copies read only by the checks below
    logic [15:0] pend_q;
    logic [3:0] ins_prev_q;
    always_ff @(posedge clk) begin
        pend_q <= pend;
        ins_prev_q <= in_service_q;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_ack;
        vec_req_q && vec_ack;
    endsequence

    a_edge_sets_flag: assert property (
        ext_edge[0] |=> flags_q[irel_pkg::F_EXT0])
        else $error("edge on input 0 did not set its flag");

    a_level_follows_pin: assert property (
        !ext_trig_type[1] |=> flags_q[irel_pkg::F_EXT1]
                              == !$past(ext_irq_in_n[1]))
        else $error("level flag 1 does not follow its pin");

    a_edge_auto_clear: assert property (
        s_ack and vec_src_q == irel_pkg::S_EXT0 && ext_trig_type[0]
        && !hw_set[0] && !sw_flag_set[0] |=> !flags_q[irel_pkg::F_EXT0])
        else $error("edge flag 0 not cleared on vectoring");

    a_tmr_auto_clear: assert property (
        s_ack and vec_src_q == irel_pkg::S_TMR0
        && !hw_set[irel_pkg::F_TMR0] && !sw_flag_set[irel_pkg::F_TMR0]
        |=> !flags_q[irel_pkg::F_TMR0])
        else $error("timer 0 flag not cleared on vectoring");

    a_ser_flag_keeps: assert property (
        s_ack and vec_src_q == irel_pkg::S_SER0
        && flags_q[irel_pkg::F_S0RX] && !sw_flag_clr[irel_pkg::F_S0RX]
        |=> flags_q[irel_pkg::F_S0RX])
        else $error("serial 0 rx flag cleared by vectoring");

    a_sw_set_flag: assert property (
        sw_flag_set[irel_pkg::F_SPI] |=> flags_q[irel_pkg::F_SPI][*2])
        else $error("software set of transfer flag lost");

    a_global_gate: assert property (
        !basic_enable_reg[irel_pkg::GLOBAL_EN_BIT] |=> !$rose(vec_req_q))
        else $error("request raised with global enable off");

    a_req_enabled: assert property (
        $rose(vec_req_q) |-> pend_q[vec_src_q]
                             && $past(instr_final) && !$past(reti))
        else $error("strobe for a source that was not pending");

    a_no_preempt: assert property (
        $rose(vec_req_q) |-> !lvl_blocked(
            level_of(prio_hi, prio_lo, vec_src_q), ins_prev_q))
        else $error("request at a level already in service");

    a_ack_pushes: assert property (
        s_ack |=> !vec_req_q ##0 (in_service_q != 4'h0))
        else $error("ack did not drop strobe or mark service");

    a_sys_redirect: assert property (
        flags_q[irel_pkg::F_S0TX] && ser_tx_redirect_en |-> req[11])
        else $error("redirected tx flag missing from system request");

endmodule

// *** tb/irel_core_model.sv ***
// Core stand-in that takes vectored calls and later returns from them
module irel_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic vec_req_q,
    input wire logic [3:0] ack_delay,
    input wire logic [7:0] svc_len,
    output logic vec_ack,
    output logic reti
);
    timeunit 1ns;
    timeprecision 1ps;
    int n = 0;
    // A withdrawn strobe restarts the wait, so a late ack is never stale
    initial begin
        vec_ack = 1'h0;
        reti = 1'h0;
        forever begin
            @(posedge clk);
            #1;
            n = (rst_n && vec_req_q) ? n + 1 : 0;
            if (n > ack_delay) begin
                vec_ack = 1'h1;
                @(posedge clk);
                #1;
                vec_ack = 1'h0;
                n = 0;
                repeat (svc_len) @(posedge clk);
                #1;
                reti = 1'h1;
                @(posedge clk);
                #1;
                reti = 1'h0;
            end
        end
    end
endmodule

// *** tb/tb_irel_top.sv ***
// Self-checking bench for the interrupt request and enable logic
module tb_irel_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [3:0] pin_n = 4'hf;
    logic [3:0] trig = 4'hf;
    logic [30:0] hw_set = '0;
    logic [30:0] sw_set = '0;
    logic [30:0] sw_clr = '0;
    logic redir = 1'h0;
    logic [15:0] en = 16'h0;
    logic glob = 1'h0;
    logic b6 = 1'h0;
    logic [15:0] ph = 16'h0;
    logic [15:0] pl = 16'h0;
    logic fin = 1'h1;
    logic wr = 1'h0;
    logic [3:0] dly = 4'h0;
    logic vec_ack, reti, vec_req_q;
    logic [30:0] flags_q;
    logic [7:0] tcf, xcf;
    logic [3:0] vec_src_q, in_service_q;
    logic [15:0] vec_addr_q;
    logic [3:0] exp_q[$];
    int errors = 0;
    int check_count = 0;
    int src_tab[31] = '{0, 2, 6, 7, 1, 3, 4, 4, 5, 5, 8, 9, 10, 10, 10, 10,
        10, 10, 10, 11, 11, 11, 11, 11, 11, 11, 12, 12, 13, 14, 15};

    initial forever #10 clk = ~clk;

    irel_top i_dut (.clk(clk), .rst_n(rst_n), .ext_irq_in_n(pin_n),
        .ext_trig_type(trig), .periph_flag_set(hw_set),
        .sw_flag_set(sw_set), .sw_flag_clr(sw_clr),
        .ser_tx_redirect_en(redir),
        .basic_enable_reg({glob, b6, en[5:0]}), .ext_en_2(en[6]),
        .ext_en_3(en[7]), .extended_enable_reg(en[15:8]),
        .prio_hi(ph), .prio_lo(pl), .instr_final(fin), .ctrl_reg_wr(wr),
        .reti(reti), .vec_ack(vec_ack), .flags_q(flags_q),
        .timer_ctrl_flags_q(tcf), .ext_irq_ctrl_flags_q(xcf),
        .vec_req_q(vec_req_q), .vec_src_q(vec_src_q),
        .vec_addr_q(vec_addr_q), .in_service_q(in_service_q));

    irel_core_model i_core (.clk(clk), .rst_n(rst_n), .vec_req_q(vec_req_q),
        .ack_delay(dly), .svc_len(8'h6), .vec_ack(vec_ack), .reti(reti));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Waits for the queue to empty, or for the core to finish service
    task automatic wait_until(input bit svc);
        int i;
        for (i = 0; i < 300; i++) begin
            if (svc ? in_service_q === 4'h0 : exp_q.size() == 0)
                break;
            tick(1);
        end
        if (i == 300) begin
            errors++;
            $display("unexpected at %0t: wait ran out", $time);
            report_and_stop();
        end
    endtask

    task automatic raise(input int b);
        if (b < 4)
            pin_n[b] = 1'h0;
        else if ($urandom % 2)
            hw_set[b] = 1'h1;
        else
            sw_set[b] = 1'h1;
        tick(1);
        pin_n = 4'hf;
        hw_set = '0;
        sw_set = '0;
    endtask

    task automatic drop(input int b);
        sw_clr[b] = 1'h1;
        tick(1);
        sw_clr = '0;
    endtask

    task automatic serve(input int b, input logic [3:0] s,
        input logic [15:0] m);
        dly = 4'($urandom % 4);
        en = m & ~(16'h1 << s);
        raise(b);
        tick(3);
        check(vec_req_q, 0, "request while disabled");
        exp_q.push_back(s);
        en = m;
        wait_until(0);
        check(in_service_q, 1, "service level");
        if (b < 6)
            check(flags_q, 0, "auto clear");
        else if (b < 10)
            check(flags_q, 32'h1 << b, "kept");
        else if (b < 12)
            check(flags_q, 32'h1 << b, "kept");
        else if (b < 26)
            check(flags_q, 32'h1 << b, "kept");
        else if (b < 29)
            check(flags_q, 32'h1 << b, "kept");
        else
            check(flags_q, 32'h1 << b, "kept");
        drop(b);
        wait_until(1);
    endtask

    // Each vectored call is matched against the oldest expected source
    always @(posedge clk) begin
        logic [3:0] e;
        if (rst_n && vec_ack && vec_req_q) begin
            check(32'(exp_q.size() != 0), 1, "vectored call");
            if (exp_q.size() != 0) begin
                e = exp_q.pop_front();
                check(vec_src_q, e, "source");
                check(vec_addr_q, irel_pkg::VEC_BASE + irel_pkg::VEC_STEP * e,
                    "vector");
            end
        end
    end

    initial begin
        int b, c;
        logic [3:0] s, t;
        void'($urandom(32'h732c));
        b6 = 1'($urandom);
        repeat (6) @(negedge clk);
        rst_n = 1'h1;
        check(flags_q, 0, "reset flags");
        check({vec_req_q, vec_addr_q, in_service_q}, 21'h30,
            "reset vector");
        en = 16'hffff;
        sw_set = '1;
        sw_clr = '1;
        tick(1);
        sw_set = '0;
        sw_clr = '0;
        tick(3);
        check(flags_q, 32'h7fffffff, "set all");
        check({tcf, xcf}, 16'haa22, "flag copies");
        check(vec_req_q, 0, "global off");
        drop(0);
        check(tcf, 8'ha8, "flag 0 copy");
        tick(1);
        sw_clr = '1;
        tick(1);
        sw_clr = '0;
        check(flags_q, 0, "clear all");
        glob = 1'h1;
        for (b = 0; b < 31; b++)
            serve(b, 4'(src_tab[b]), 16'hffff);
        redir = 1'h1;
        serve(7, 4'hb, 16'hffef);
        redir = 1'h0;
        en = 16'hffff;
        trig = 4'h0;
        for (b = 0; b < 4; b++) begin
            exp_q.push_back(4'(src_tab[b]));
            pin_n[b] = 1'h0;
            wait_until(0);
            check(flags_q[b], 1, "level flag held");
            pin_n[b] = 1'h1;
            tick(2);
            check(flags_q[b], 0, "level flag follows pin");
            wait_until(1);
        end
        exp_q.push_back(4'h8);
        fin = 1'h0;
        raise(10);
        tick(3);
        check(vec_req_q, 0, "not final cycle");
        fin = 1'h1;
        wr = 1'h1;
        tick(3);
        check(vec_req_q, 0, "enable write");
        wr = 1'h0;
        wait_until(0);
        drop(10);
        wait_until(1);
        repeat (8) begin
            b = 4 + $urandom % 27;
            c = 4 + $urandom % 27;
            if (src_tab[b] == src_tab[c])
                continue;
            ph = 16'($urandom);
            pl = 16'($urandom);
            s = 4'(src_tab[b]);
            t = 4'(src_tab[c]);
            if ({ph[t], pl[t]} > {ph[s], pl[s]} ||
                ({ph[t], pl[t]} == {ph[s], pl[s]} && t < s))
                {b, c} = {c, b};
            exp_q.push_back(4'(src_tab[b]));
            hw_set[b] = 1'h1;
            hw_set[c] = 1'h1;
            tick(1);
            hw_set = '0;
            wait_until(0);
            s = 4'(src_tab[b]);
            check(in_service_q, 1 << {ph[s], pl[s]}, "level");
            drop(b);
            exp_q.push_back(4'(src_tab[c]));
            wait_until(0);
            drop(c);
            wait_until(1);
        end
        report_and_stop();
    end
endmodule
